// *** shared/prsc_pkg.sv ***
// Constants and types for the reference switchover control block.
// Assumes an APB slave with 32-bit data and a 40 MHz system clock.
`default_nettype none
package prsc_pkg;
  // Register byte offsets
  localparam logic [11:0] REG_SWITCH_CTRL = 12'h01C;
  localparam logic [11:0] REG_STATUS_SEL  = 12'h020;
  localparam logic [11:0] REG_IRQ_STATUS  = 12'h024;
  localparam logic [11:0] REG_IRQ_MASK    = 12'h028;
  localparam logic [11:0] REG_LIVE_STATE  = 12'h02C;
  // Switchover control field positions
  localparam int BIT_DIFF_MODE  = 0;
  localparam int BIT_PWR_PRI    = 1;
  localparam int BIT_PWR_SEC    = 2;
  localparam int BIT_STAY_SEC   = 3;
  localparam int BIT_AUTO_MODE  = 4;
  localparam int BIT_USE_PIN    = 5;
  localparam int BIT_SEL_SEC    = 6;
  localparam int BIT_NO_DEGLTCH = 7;
  // Reset values
  localparam logic [7:0] SWITCH_CTRL_RST = 8'h00;
  localparam logic [4:0] STATUS_SEL_RST  = 5'h00;
  localparam logic [2:0] IRQ_MASK_RST    = 3'h0;
  // Status selector codes
  localparam logic [4:0] SEL_LOCK_AND = 5'h1A;
  localparam logic [4:0] SEL_VCO_N    = 5'h1B;
  localparam logic [4:0] SEL_REF_USED = 5'h1C;
  localparam logic [4:0] SEL_LOCK_N   = 5'h1D;
  localparam logic [4:0] SEL_HOLD_N   = 5'h1E;
  // Interrupt bit positions
  localparam int IRQ_SWITCHED  = 0;
  localparam int IRQ_PRI_BAD   = 1;
  localparam int IRQ_PRI_GOOD  = 2;
  // Deglitch: reference change waits this long
  localparam int DEGLITCH_NS     = 200;
  localparam int CLK_PERIOD_NS   = 25;
  localparam int DEGLITCH_CYCLES = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] DEGLITCH_LOAD = 4'(DEGLITCH_CYCLES);
  // Switchover state
  typedef enum logic [2:0] {
    PRSC_ON_PRI  = 3'b001,
    PRSC_MOVING  = 3'b010,
    PRSC_ON_SEC  = 3'b100
  } prsc_state_e;
endpackage
`default_nettype wire

// *** shared/prsc_if.sv ***
// Interface between the top block and the reference status selector.
// Assumes both ends run on the same clock; signals are plain levels.
`default_nettype none
interface prsc_status_if;
  logic [4:0] sel_code;
  logic       lock_ok;
  logic       sel_ref_ok;
  logic       vco_ok;
  logic       on_primary;
  logic       holdover;
  logic       level_out;
  modport ctrl (output sel_code, output lock_ok, output sel_ref_ok, output vco_ok,
                output on_primary, output holdover, input level_out);
  modport mux  (input sel_code, input lock_ok, input sel_ref_ok, input vco_ok,
                input on_primary, input holdover, output level_out);
endinterface
`default_nettype wire

// *** hw/prsc_status_mux.sv ***
// Status pin level selector for the upper selector codes.
// Assumes inputs already synchronised to ref_clk.
`default_nettype none
module prsc_status_mux (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  prsc_status_if.mux st
);
  logic level_reg;
  logic level_next;

  // Decode the selector code into a static level
  always_comb
  begin
    level_next = 1'b0;
    case (st.sel_code)
      prsc_pkg::SEL_LOCK_AND: level_next = st.lock_ok & st.sel_ref_ok & st.vco_ok;
      prsc_pkg::SEL_VCO_N:    level_next = ~st.vco_ok;
      prsc_pkg::SEL_REF_USED: level_next = st.on_primary;
      prsc_pkg::SEL_LOCK_N:   level_next = ~st.lock_ok;
      prsc_pkg::SEL_HOLD_N:   level_next = ~st.holdover;
      default:                level_next = 1'b0;
    endcase
  end

  // Register so the pin never glitches on decode
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      level_reg <= 1'b0;
    else
      level_reg <= level_next;
  end

  assign st.level_out = level_reg;

  property p_lock_and;
    @(posedge ref_clk) disable iff (sys_rst)
    (st.sel_code == prsc_pkg::SEL_LOCK_AND) |=>
      (level_reg == $past(st.lock_ok & st.sel_ref_ok & st.vco_ok));
  endproperty
  a_lock_and: assert property (p_lock_and) else $error("lock AND level wrong");

  property p_ref_used;
    @(posedge ref_clk) disable iff (sys_rst)
    (st.sel_code == prsc_pkg::SEL_REF_USED) |=> (level_reg == $past(st.on_primary));
  endproperty
  a_ref_used: assert property (p_ref_used) else $error("reference used level wrong");

  property p_hold_n;
    @(posedge ref_clk) disable iff (sys_rst)
    (st.sel_code == prsc_pkg::SEL_HOLD_N) |=> (level_reg != $past(st.holdover));
  endproperty
  a_hold_n: assert property (p_hold_n) else $error("holdover level not inverted");
endmodule
`default_nettype wire

// *** hw/prsc_top.sv ***
// Reference switchover control with APB registers and status pin.
// Assumes status inputs and select pin are asynchronous to ref_clk.
`default_nettype none
module prsc_top (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  input  wire logic        ref_sel_pin,
  input  wire logic        pri_status_in,
  input  wire logic        sec_status_in,
  input  wire logic        vco_status_in,
  input  wire logic        lock_in,
  input  wire logic        holdover_in,
  output logic             use_secondary,
  output logic             pri_power_on,
  output logic             sec_power_on,
  output logic             diff_mode,
  output logic             status_pin,
  output logic             irq
);
  // Two-flop synchronisers for every pin input
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
    end
    else
    begin
      sync1_reg <= {holdover_in, lock_in, vco_status_in, sec_status_in,
                    pri_status_in, ref_sel_pin};
      sync2_reg <= sync1_reg;
    end
  end
  logic pin_sel, pri_ok, sec_ok, vco_ok, lock_ok, hold_on;
  assign {hold_on, lock_ok, vco_ok, sec_ok, pri_ok, pin_sel} = sync2_reg;

  // Registers
  logic [7:0] ctrl_reg, ctrl_next;
  logic [4:0] ssel_reg, ssel_next;
  logic [2:0] mask_reg, mask_next;
  logic [2:0] stat_reg, stat_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        err_reg, err_next;
  logic [2:0]  events;

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == prsc_pkg::REG_SWITCH_CTRL) || (a == prsc_pkg::REG_STATUS_SEL) ||
                (a == prsc_pkg::REG_IRQ_STATUS) || (a == prsc_pkg::REG_IRQ_MASK) ||
                (a == prsc_pkg::REG_LIVE_STATE);
  endfunction

  wire access = psel & penable;
  wire wr_acc = access & pwrite;
  wire rd_acc = access & ~pwrite;

  prsc_pkg::prsc_state_e state_reg, state_next;
  logic       applied_sec_reg, applied_sec_next;
  logic [3:0] dg_cnt_reg, dg_cnt_next;

  // APB decode; zero-wait answers in the access phase
  always_comb
  begin
    ctrl_next  = ctrl_reg;
    ssel_next  = ssel_reg;
    mask_next  = mask_reg;
    rdata_next = rdata_reg;
    err_next   = 1'b0;
    stat_next  = stat_reg;
    if (psel & ~penable)
    begin
      err_next = ~is_mapped(paddr);
      rdata_next = 32'h0000_0000;
      case (paddr)
        prsc_pkg::REG_SWITCH_CTRL: rdata_next = {24'h00_0000, ctrl_reg};
        prsc_pkg::REG_STATUS_SEL:  rdata_next = {27'h000_0000, ssel_reg};
        prsc_pkg::REG_IRQ_STATUS:  rdata_next = {29'h0000_0000, stat_reg};
        prsc_pkg::REG_IRQ_MASK:    rdata_next = {29'h0000_0000, mask_reg};
        prsc_pkg::REG_LIVE_STATE:
          rdata_next = {24'h00_0000, 1'b0, state_reg, hold_on, lock_ok,
                        applied_sec_reg, pri_ok};
        default:                   rdata_next = 32'h0000_0000;
      endcase
    end
    if (wr_acc)
    begin
      case (paddr)
        prsc_pkg::REG_SWITCH_CTRL: ctrl_next = pwdata[7:0];
        prsc_pkg::REG_STATUS_SEL:  ssel_next = pwdata[4:0];
        prsc_pkg::REG_IRQ_MASK:    mask_next = pwdata[2:0];
        default:                   ctrl_next = ctrl_reg;
      endcase
    end
    // Read clears only what setup reported; later events survive
    if (rd_acc && paddr == prsc_pkg::REG_IRQ_STATUS)
      stat_next = (stat_reg & ~rdata_reg[2:0]) | events;
    else
      stat_next = stat_reg | events;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ctrl_reg  <= prsc_pkg::SWITCH_CTRL_RST;
      ssel_reg  <= prsc_pkg::STATUS_SEL_RST;
      mask_reg  <= prsc_pkg::IRQ_MASK_RST;
      stat_reg  <= 3'h0;
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
    end
    else
    begin
      ctrl_reg  <= ctrl_next;
      ssel_reg  <= ssel_next;
      mask_reg  <= mask_next;
      stat_reg  <= stat_next;
      rdata_reg <= rdata_next;
      err_reg   <= err_next;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = access & err_reg;
  assign prdata  = rdata_reg;
  assign irq     = |(stat_reg & mask_reg);

  wire auto_mode = ctrl_reg[prsc_pkg::BIT_AUTO_MODE];
  wire stay_sec  = ctrl_reg[prsc_pkg::BIT_STAY_SEC];

  // Wanted reference from mode bits and the automatic state
  logic want_sec;
  always_comb
  begin
    if (auto_mode)
      want_sec = (state_reg != prsc_pkg::PRSC_ON_PRI);
    else if (ctrl_reg[prsc_pkg::BIT_USE_PIN])
      want_sec = pin_sel;
    else
      want_sec = ctrl_reg[prsc_pkg::BIT_SEL_SEC];
  end

  // Automatic switchover state machine
  always_comb
  begin
    state_next = state_reg;
    events     = 3'h0;
    case (state_reg)
      prsc_pkg::PRSC_ON_PRI:
      begin
        if (auto_mode && !pri_ok)
        begin
          state_next = prsc_pkg::PRSC_MOVING;
          events[prsc_pkg::IRQ_PRI_BAD] = 1'b1;
        end
      end
      prsc_pkg::PRSC_MOVING:
      begin
        state_next = prsc_pkg::PRSC_ON_SEC;
        events[prsc_pkg::IRQ_SWITCHED] = 1'b1;
      end
      prsc_pkg::PRSC_ON_SEC:
      begin
        if (!auto_mode)
          state_next = prsc_pkg::PRSC_ON_PRI;
        else if (pri_ok && !stay_sec)
        begin
          state_next = prsc_pkg::PRSC_ON_PRI;
          events[prsc_pkg::IRQ_PRI_GOOD] = 1'b1;
        end
      end
      default: state_next = prsc_pkg::PRSC_ON_PRI;
    endcase
  end

  // Deglitch: hold the old reference for a settle time before changing
  always_comb
  begin
    applied_sec_next = applied_sec_reg;
    dg_cnt_next      = dg_cnt_reg;
    if (want_sec == applied_sec_reg)
      dg_cnt_next = prsc_pkg::DEGLITCH_LOAD;
    else if (ctrl_reg[prsc_pkg::BIT_NO_DEGLTCH] || dg_cnt_reg == 4'h1)
      applied_sec_next = want_sec;
    else
      dg_cnt_next = dg_cnt_reg - 4'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_reg       <= prsc_pkg::PRSC_ON_PRI;
      applied_sec_reg <= 1'b0;
      dg_cnt_reg      <= prsc_pkg::DEGLITCH_LOAD;
    end
    else
    begin
      state_reg       <= state_next;
      applied_sec_reg <= applied_sec_next;
      dg_cnt_reg      <= dg_cnt_next;
    end
  end

  assign use_secondary = applied_sec_reg;
  assign diff_mode     = ctrl_reg[prsc_pkg::BIT_DIFF_MODE];
  assign pri_power_on  = auto_mode | ctrl_reg[prsc_pkg::BIT_PWR_PRI];
  assign sec_power_on  = auto_mode | ctrl_reg[prsc_pkg::BIT_PWR_SEC];

  // Status selector on its own module
  prsc_status_if st ();
  assign st.sel_code   = ssel_reg;
  assign st.lock_ok    = lock_ok;
  assign st.sel_ref_ok = applied_sec_reg ? sec_ok : pri_ok;
  assign st.vco_ok     = vco_ok;
  assign st.on_primary = ~applied_sec_reg;
  assign st.holdover   = hold_on;
  assign status_pin    = st.level_out;

  prsc_status_mux u_mux (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .st      (st.mux)
  );

  property p_power_auto;
    @(posedge ref_clk) disable iff (sys_rst)
    auto_mode |-> (pri_power_on && sec_power_on);
  endproperty
  a_power_auto: assert property (p_power_auto) else $error("auto mode power off");

  property p_manual_reg;
    @(posedge ref_clk) disable iff (sys_rst)
    (!auto_mode && !ctrl_reg[prsc_pkg::BIT_USE_PIN] &&
     ctrl_reg[prsc_pkg::BIT_NO_DEGLTCH]) [*2] |=>
      (applied_sec_reg == $past(ctrl_reg[prsc_pkg::BIT_SEL_SEC]));
  endproperty
  a_manual_reg: assert property (p_manual_reg) else $error("register select ignored");

  property p_manual_pin;
    @(posedge ref_clk) disable iff (sys_rst)
    (!auto_mode && ctrl_reg[prsc_pkg::BIT_USE_PIN] &&
     ctrl_reg[prsc_pkg::BIT_NO_DEGLTCH]) |=> (applied_sec_reg == $past(pin_sel));
  endproperty
  a_manual_pin: assert property (p_manual_pin) else $error("pin select ignored");

  property p_fail_move;
    @(posedge ref_clk) disable iff (sys_rst)
    (auto_mode && state_reg == prsc_pkg::PRSC_ON_PRI && !pri_ok) |=>
      (state_reg == prsc_pkg::PRSC_MOVING) ##1 (state_reg == prsc_pkg::PRSC_ON_SEC);
  endproperty
  a_fail_move: assert property (p_fail_move) else $error("no move on primary fail");

  property p_revert;
    @(posedge ref_clk) disable iff (sys_rst)
    (auto_mode && state_reg == prsc_pkg::PRSC_ON_SEC && pri_ok && !stay_sec) |=>
      (state_reg == prsc_pkg::PRSC_ON_PRI);
  endproperty
  a_revert: assert property (p_revert) else $error("no revert to primary");

  property p_stay;
    @(posedge ref_clk) disable iff (sys_rst)
    (auto_mode && stay_sec && state_reg == prsc_pkg::PRSC_ON_SEC) |=>
      (state_reg == prsc_pkg::PRSC_ON_SEC);
  endproperty
  a_stay: assert property (p_stay) else $error("left secondary while staying");

  property p_deglitch;
    @(posedge ref_clk) disable iff (sys_rst)
    (!ctrl_reg[prsc_pkg::BIT_NO_DEGLTCH] && $changed(applied_sec_reg)) |->
      (applied_sec_reg == $past(want_sec, prsc_pkg::DEGLITCH_CYCLES));
  endproperty
  a_deglitch: assert property (p_deglitch) else $error("deglitch change unexpected");

  property p_mode_manual;
    @(posedge ref_clk) disable iff (sys_rst)
    !auto_mode |=> (state_reg != prsc_pkg::PRSC_MOVING) || $past(auto_mode);
  endproperty
  a_mode_manual: assert property (p_mode_manual) else $error("manual mode switched");
endmodule
`default_nettype wire

// *** tb/prsc_ref_model.sv ***
// Reference status sources and select pin driven from bench commands.
// Assumes the bench changes cmd just after a rising edge.
`default_nettype none
module prsc_ref_model (
  input  wire logic       ref_clk,
  input  wire logic       slow,
  input  wire logic [5:0] cmd,
  output logic      [5:0] lines
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] stage_reg;
  // Extra stage mimics a source that reports late
  always_ff @(posedge ref_clk)
  begin
    stage_reg <= cmd;
    lines     <= slow ? stage_reg : cmd;
  end
endmodule
`default_nettype wire

// *** tb/tb_prsc_top.sv ***
// Self-checking bench for the reference switchover control block.
// Assumes zero-wait APB and levels from the reference source model.
`default_nettype none
module tb_prsc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [5:0]  cmd     = 6'h1E;
  logic        slow    = 1'b0;
  logic [5:0]  lines;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready, pslverr, use_sec, pri_pw, sec_pw, diff, st_pin, irq, err;
  integer      n_mismatch = 0;
  integer      cmp_count  = 0;
  integer      seed       = 18;
  integer      i, k, n;
  logic [4:0]  code;
  logic [5:0]  rnd_lines;
  logic        exp_q[$];

  // Free-running 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  prsc_top prsc_top_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .ref_sel_pin(lines[0]),
    .pri_status_in(lines[1]), .sec_status_in(lines[2]), .vco_status_in(lines[3]),
    .lock_in(lines[4]), .holdover_in(lines[5]), .use_secondary(use_sec),
    .pri_power_on(pri_pw), .sec_power_on(sec_pw), .diff_mode(diff),
    .status_pin(st_pin), .irq(irq));
  prsc_ref_model prsc_ref_model_inst (.ref_clk(ref_clk), .slow(slow), .cmd(cmd),
    .lines(lines));

  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    chk_reg({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    integer w;
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    w = 0;
    do
    begin
      @(posedge ref_clk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    if (w >= 50)
      n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Bounded wait on the routed reference, sampled mid-cycle
  task automatic wait_sel(input logic v, output integer c);
    c = 0;
    while (use_sec !== v && c < 40)
    begin
      @(negedge ref_clk);
      c++;
    end
  endtask

  // Expected status level from the source levels and routing
  function automatic logic pin_model(input logic [4:0] c, input logic [5:0] v,
                                     input logic s);
    case (c)
      5'h1A: return v[4] & (s ? v[2] : v[1]) & v[3];
      5'h1B: return ~v[3];
      5'h1C: return ~s;
      5'h1D: return ~v[4];
      5'h1E: return ~v[5];
      default: return 1'b0;
    endcase
  endfunction

  // Hang guard, well past the expected run length
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    give_verdict();
  end

  initial
  begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Register defaults, then an unmapped place
    for (i = 0; i < 4; i++)
    begin
      apb(1'b0, prsc_pkg::REG_SWITCH_CTRL + 12'(4 * i), 32'h0000_0000);
      chk_reg(rd, 32'h0000_0000);
      chk_pin(err, 1'b0);
    end
    // Live state: primary good, locked, on primary, idle state
    apb(1'b0, prsc_pkg::REG_LIVE_STATE, 32'h0000_0000);
    chk_reg(rd, 32'h0000_0015);
    chk_pin(use_sec, 1'b0);
    chk_pin(pri_pw | sec_pw, 1'b0);
    apb(1'b0, 12'h030, 32'h0000_0000);
    chk_pin(err, 1'b1);
    chk_reg(rd, 32'h0000_0000);
    // Unmapped write must not reach the control register
    apb(1'b1, 12'h030, 32'hFFFF_FFFF);
    apb(1'b0, prsc_pkg::REG_SWITCH_CTRL, 32'h0000_0000);
    chk_reg(rd, 32'h0000_0000);
    // Register select: deglitch slows the change, bit 7 skips it
    apb(1'b1, prsc_pkg::REG_SWITCH_CTRL, 32'h0000_0040);
    wait_sel(1'b1, n);
    chk_reg(n, prsc_pkg::DEGLITCH_CYCLES + 1);
    chk_pin(use_sec, 1'b1);
    apb(1'b1, prsc_pkg::REG_SWITCH_CTRL, 32'h0000_0080);
    wait_sel(1'b0, n);
    chk_reg(n, 32'h0000_0002);
    // Pin select overrides bit 6
    apb(1'b1, prsc_pkg::REG_SWITCH_CTRL, 32'h0000_00E0);
    repeat (10) @(negedge ref_clk);
    chk_pin(use_sec, 1'b0);
    @(posedge ref_clk);
    cmd[0] <= 1'b1;
    wait_sel(1'b1, n);
    chk_pin(use_sec, 1'b1);
    // Power enables follow bits 2:1 only in manual mode
    for (k = 0; k < 4; k++)
    begin
      apb(1'b1, prsc_pkg::REG_SWITCH_CTRL, 32'(k * 2));
      @(negedge ref_clk);
      chk_reg({30'h0, sec_pw, pri_pw}, 32'(k));
    end
    apb(1'b1, prsc_pkg::REG_SWITCH_CTRL, 32'h0000_0001);
    @(negedge ref_clk);
    chk_reg({29'h0, diff, sec_pw, pri_pw}, 32'h0000_0004);
    // Automatic mode with only primary-bad interrupt unmasked
    apb(1'b1, prsc_pkg::REG_IRQ_MASK, 32'h0000_0002);
    apb(1'b1, prsc_pkg::REG_SWITCH_CTRL, 32'h0000_0010);
    apb(1'b0, prsc_pkg::REG_IRQ_STATUS, 32'h0000_0000);
    chk_reg({30'h0, sec_pw, pri_pw}, 32'h0000_0003);
    cmd[1] <= 1'b0;
    wait_sel(1'b1, n);
    chk_pin(use_sec, 1'b1);
    chk_pin(irq, 1'b1);
    apb(1'b0, prsc_pkg::REG_IRQ_STATUS, 32'h0000_0000);
    chk_reg(rd, 32'h0000_0003);
    @(negedge ref_clk);
    chk_pin(irq, 1'b0);
    // Source changes only just after a rising edge
    @(posedge ref_clk);
    cmd[1] <= 1'b1;
    wait_sel(1'b0, n);
    chk_pin(use_sec, 1'b0);
    chk_pin(irq, 1'b0);
    apb(1'b0, prsc_pkg::REG_IRQ_STATUS, 32'h0000_0000);
    chk_reg(rd, 32'h0000_0004);
    // Stay bit set, slow source: no return to primary
    slow <= 1'b1;
    apb(1'b1, prsc_pkg::REG_SWITCH_CTRL, 32'h0000_0018);
    cmd[1] <= 1'b0;
    wait_sel(1'b1, n);
    chk_pin(use_sec, 1'b1);
    @(posedge ref_clk);
    cmd[1] <= 1'b1;
    repeat (40) @(negedge ref_clk);
    chk_pin(use_sec, 1'b1);
    // Status selector codes with random source levels, both routings
    @(posedge ref_clk);
    slow <= 1'b0;
    for (k = 0; k < 2; k++)
    begin
      apb(1'b1, prsc_pkg::REG_SWITCH_CTRL, (k == 1) ? 32'h0000_00C0 : 32'h0000_0000);
      wait_sel(k[0], n);
      for (i = 0; i < 24; i++)
      begin
        code = 5'(5'h1A + i % 6);
        apb(1'b1, prsc_pkg::REG_STATUS_SEL, {27'h0, code});
        rnd_lines = 6'($random(seed));
        cmd <= rnd_lines;
        // Expected level queued when the stimulus is chosen
        exp_q.push_back(pin_model(code, rnd_lines, k[0]));
        repeat (6) @(negedge ref_clk);
        chk_pin(st_pin, exp_q.pop_front());
      end
    end
    give_verdict();
  end
endmodule
`default_nettype wire
